// *** design/tpda_arbiter.sv ***
// text page display arbiter: picks one of 32 pages for the display
// assumes page enables and acks arrive unsynchronised; one clock domain
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module tpda_arbiter
	import tpda_pkg::*;
#(
	parameter int SEC_CYC = tpda_pkg::SEC_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [31:0] page_enable_in,
	input wire logic [31:0] alarm_ack_in,
	input wire logic [7:0] language_select_byte,
	input wire logic [2:0] elem_row,
	input wire logic [3:0] elem_col,
	input wire logic elem_colour_valid,
	input wire logic [1:0] elem_colour,
	output logic [31:0] enable_echo_out,
	output logic [31:0] ack_pulse_out,
	output logic [4:0] shown_page_out,
	output logic shown_valid_out,
	output logic [1:0] backlight_output,
	output logic [7:0] button_enable_out,
	output logic [2:0] language_out,
	output logic [11:0] cell_addr_out,
	output logic cell_valid_out,
	output logic [1:0] colour_out
);
	import tpda_pkg::*;

	// ==================================================================
	// input sampling
	logic [31:0] en_s, ack_rise;

	tpda_edge_sync #(.WIDTH(PAGES)) u_en_sync (
		.clk_sys(clk_sys), .rstn(rstn), .d_in(page_enable_in),
		.lvl(en_s), .rise()
	);
	tpda_edge_sync #(.WIDTH(PAGES)) u_ack_sync (
		.clk_sys(clk_sys), .rstn(rstn), .d_in(alarm_ack_in),
		.lvl(), .rise(ack_rise)
	);

	// ==================================================================
	// register file
	logic [31:0] cfg_mem [PAGES];
	logic [8:0] ltab_mem [LANGS];
	logic [31:0] ctrl_reg;
	logic [2:0] ldef_reg;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] wcfg;
	logic [4:0] wroll;
	logic [5:0] q_cnt_reg;
	logic shown_valid_reg, alarm_shown_reg;
	logic [4:0] shown_reg;
	logic [2:0] lang_reg;

	// rolling time outside 1..30 s is clamped so the timer never stalls
	always_comb begin
		wroll = reg_wdata[PCFG_ROLL_LSB +: 5];
		if (wroll < ROLL_MIN_S) wroll = ROLL_MIN_S;
		if (wroll > ROLL_MAX_S) wroll = ROLL_MAX_S;
		wcfg = reg_wdata;
		wcfg[PCFG_ROLL_LSB +: 5] = wroll;
		wcfg[23:19] = 5'h00;
		wcfg[7:5] = 3'h0;
		wcfg[15:13] = 3'h0;
		if (reg_wdata[PCFG_LIGHT_LSB +: 2] == 2'h3) wcfg[PCFG_LIGHT_LSB +: 2] = TPDA_WHITE;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			for (int i = 0; i < PAGES; i++) cfg_mem[i] <= PCFG_RESET;
			for (int i = 0; i < LANGS; i++) ltab_mem[i] <= 9'h000;
			ctrl_reg <= CTRL_RESET;
			ldef_reg <= 3'h0;
		end else if (reg_wr) begin
			if (reg_addr < ADDR_CTRL) cfg_mem[reg_addr[4:0]] <= wcfg;
			if (reg_addr == ADDR_CTRL) ctrl_reg <= {30'h0000_0000, reg_wdata[1:0]};
			if (reg_addr == ADDR_LANG_DEF) ldef_reg <= reg_wdata[2:0];
			if (reg_addr[7:3] == ADDR_LANG_TAB[7:3]) ltab_mem[reg_addr[2:0]] <= reg_wdata[8:0];
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (reg_rd) begin
			if (reg_addr < ADDR_CTRL) rdata_next = cfg_mem[reg_addr[4:0]];
			else if (reg_addr == ADDR_CTRL) rdata_next = ctrl_reg;
			else if (reg_addr == ADDR_LANG_DEF) rdata_next = {29'h0000_0000, ldef_reg};
			else if (reg_addr[7:3] == ADDR_LANG_TAB[7:3])
				rdata_next = {23'h00_0000, ltab_mem[reg_addr[2:0]]};
			else if (reg_addr == ADDR_STATUS) begin
				rdata_next[4:0] = shown_reg;
				rdata_next[STAT_VALID_BIT] = shown_valid_reg;
				rdata_next[STAT_ALARM_BIT] = alarm_shown_reg;
				rdata_next[STAT_LANG_LSB +: 3] = lang_reg;
				rdata_next[STAT_QCNT_LSB +: 6] = q_cnt_reg;
			end
		end
	end
	// ==================================================================
	// per-page decode
	logic [31:0] alarm_cfg;
	logic [4:0] prio [PAGES];
	logic [4:0] roll [PAGES];

	for (genvar g = 0; g < PAGES; g++) begin : g_page
		assign alarm_cfg[g] = cfg_mem[g][PCFG_ALARM_BIT];
		assign prio[g] = cfg_mem[g][PCFG_PRIO_LSB +: 5]; // code 0 means priority 1
		assign roll[g] = cfg_mem[g][PCFG_ROLL_LSB +: 5];
	end

	// ==================================================================
	// alarm queue in order of enable
	logic [4:0] q_mem [PAGES];
	logic [4:0] head_reg, head_next, tail_reg, tail_next;
	logic [5:0] q_cnt_next;
	logic [31:0] queued_reg, queued_next, acked_reg, acked_next;
	logic push, pop, ack_hit, head_ok;
	logic [4:0] push_idx, head_idx;

	assign head_idx = q_mem[head_reg];
	assign head_ok = (q_cnt_reg != 6'h00) && en_s[head_idx];
	// only a rise at the alarm page now on the display counts
	assign ack_hit = head_ok && alarm_shown_reg && shown_reg == head_idx
		&& ack_rise[head_idx];

	always_comb begin
		push = 1'b0;
		push_idx = 5'h00;
		for (int i = PAGES - 1; i >= 0; i--) begin
			if (en_s[i] && alarm_cfg[i] && !queued_reg[i] && !acked_reg[i]) begin
				push = 1'b1;
				push_idx = 5'(i);
			end
		end
		pop = (q_cnt_reg != 6'h00) && (!en_s[head_idx] || ack_hit);
		head_next = pop ? head_reg + 5'h01 : head_reg;
		tail_next = push ? tail_reg + 5'h01 : tail_reg;
		q_cnt_next = q_cnt_reg + {5'h00, push} - {5'h00, pop};
		queued_next = queued_reg;
		acked_next = acked_reg & en_s;
		if (pop) queued_next[head_idx] = 1'b0;
		if (push) queued_next[push_idx] = 1'b1;
		// an acked page stays out until its enable falls and rises again
		if (ack_hit) acked_next[head_idx] = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			head_reg <= 5'h00;
			tail_reg <= 5'h00;
			q_cnt_reg <= 6'h00;
			queued_reg <= 32'h0000_0000;
			acked_reg <= 32'h0000_0000;
		end else begin
			head_reg <= head_next;
			tail_reg <= tail_next;
			q_cnt_reg <= q_cnt_next;
			queued_reg <= queued_next;
			acked_reg <= acked_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) q_mem[tail_reg] <= push_idx;
	end

	// ==================================================================
	// priority and rotation select
	logic [5:0] best;
	logic [31:0] cand;
	logic [5:0] cand_cnt;
	logic [4:0] cur_reg, cur_next, after_cur, sel;
	logic [4:0] shown_next;
	logic shown_valid_next, alarm_shown_next, expire, tmr_load, tmr_run;

	always_comb begin
		best = 6'h20;
		cand_cnt = 6'h00;
		after_cur = cur_reg;
		for (int i = 0; i < PAGES; i++) begin
			if (en_s[i] && !alarm_cfg[i] && {1'b0, prio[i]} < best) best = {1'b0, prio[i]};
		end
		for (int i = 0; i < PAGES; i++) begin
			cand[i] = en_s[i] && !alarm_cfg[i] && {1'b0, prio[i]} == best;
			cand_cnt = cand_cnt + {5'h00, cand[i]};
		end
		for (int k = PAGES; k >= 1; k--) begin
			if (cand[5'(cur_reg + 5'(k))]) after_cur = 5'(cur_reg + 5'(k));
		end
		// stay while still a candidate, move on only when the slot expires
		if (cand[cur_reg] && !(expire && cand_cnt > 6'h01)) sel = cur_reg;
		else sel = after_cur;
		cur_next = cur_reg;
		shown_next = 5'h00;
		shown_valid_next = 1'b0;
		alarm_shown_next = 1'b0;
		if (head_ok && !pop) begin
			shown_next = head_idx;
			shown_valid_next = 1'b1;
			alarm_shown_next = 1'b1;
		end else if (cand_cnt != 6'h00) begin
			shown_next = sel;
			shown_valid_next = 1'b1;
			cur_next = sel;
		end
		tmr_load = shown_next != shown_reg || shown_valid_next != shown_valid_reg
			|| alarm_shown_next != alarm_shown_reg || expire;
		tmr_run = shown_valid_reg && !alarm_shown_reg && cand_cnt > 6'h01;
	end

	tpda_roll_timer #(.SEC_CYC(SEC_CYC)) u_timer (
		.clk_sys(clk_sys), .rstn(rstn), .load(tmr_load),
		.load_sec(roll[shown_next]), .run(tmr_run), .expire(expire)
	);

	// ==================================================================
	// display side outputs
	logic [31:0] echo_reg, ackp_reg, ackp_next;
	logic [1:0] light_reg, light_next, colour_reg, colour_next;
	logic [7:0] btn_reg, btn_next;
	logic [2:0] lang_next;
	logic [11:0] cell_reg, cell_next;
	logic cell_valid_reg, cell_valid_next;

	always_comb begin
		ackp_next = 32'h0000_0000;
		if (ack_hit) ackp_next[head_idx] = 1'b1;
		light_next = TPDA_WHITE;
		btn_next = 8'h00;
		if (shown_valid_reg) begin
			light_next = cfg_mem[shown_reg][PCFG_LIGHT_LSB +: 2];
			if (ctrl_reg[CTRL_BTN_BIT]) btn_next = cfg_mem[shown_reg][PCFG_BTN_LSB +: 8];
		end
		colour_next = elem_colour_valid ? elem_colour : light_next;
		lang_next = ldef_reg;
		if (ctrl_reg[CTRL_LANG_BIT]) begin
			for (int i = LANGS - 1; i >= 0; i--) begin
				if (ltab_mem[i][LTAB_VALID_BIT] && ltab_mem[i][7:0] == language_select_byte)
					lang_next = 3'(i);
			end
		end
		cell_next = 12'(shown_reg * PAGE_CELLS) + 12'(elem_row * PAGE_COLS) + 12'(elem_col);
		cell_valid_next = shown_valid_reg && elem_row < 3'(PAGE_ROWS);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdata_reg <= 32'h0000_0000;
			echo_reg <= 32'h0000_0000;
			ackp_reg <= 32'h0000_0000;
			cur_reg <= 5'h00;
			shown_reg <= 5'h00;
			shown_valid_reg <= 1'b0;
			alarm_shown_reg <= 1'b0;
			light_reg <= TPDA_WHITE;
			colour_reg <= TPDA_WHITE;
			btn_reg <= 8'h00;
			lang_reg <= 3'h0;
			cell_reg <= 12'h000;
			cell_valid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			echo_reg <= en_s;
			ackp_reg <= ackp_next;
			cur_reg <= cur_next;
			shown_reg <= shown_next;
			shown_valid_reg <= shown_valid_next;
			alarm_shown_reg <= alarm_shown_next;
			light_reg <= light_next;
			colour_reg <= colour_next;
			btn_reg <= btn_next;
			lang_reg <= lang_next;
			cell_reg <= cell_next;
			cell_valid_reg <= cell_valid_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign enable_echo_out = echo_reg;
	assign ack_pulse_out = ackp_reg;
	assign shown_page_out = shown_reg;
	assign shown_valid_out = shown_valid_reg;
	assign backlight_output = light_reg;
	assign button_enable_out = btn_reg;
	assign language_out = lang_reg;
	assign cell_addr_out = cell_reg;
	assign cell_valid_out = cell_valid_reg;
	assign colour_out = colour_reg;

	// ==================================================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_ECHO: assert property (enable_echo_out == $past(en_s))
		else $error("echo does not follow enable");
	AST_ACK_SHOWN: assert property (ack_pulse_out != 0 |->
		$past(alarm_shown_reg) && ack_pulse_out == (32'h1 << $past(shown_reg)))
		else $error("ack pulse at a page not shown");
	AST_ONEHOT_ACK: assert property ($onehot0(ack_pulse_out))
		else $error("more than one ack pulse");
	AST_ALARM_FIRST: assert property (head_ok && !pop |=> alarm_shown_reg)
		else $error("enabled alarm not shown");
	AST_ALARM_HOLD: assert property (alarm_shown_reg && en_s[shown_reg] && !ack_hit
		|=> alarm_shown_reg && shown_reg == $past(shown_reg))
		else $error("alarm page left without ack");
	AST_ACK_IGNORED: assert property (!alarm_shown_reg |=> ack_pulse_out == 0)
		else $error("ack taken with no alarm shown");
	AST_BEST_PRIO: assert property (shown_valid_next && !alarm_shown_next
		|-> {1'b0, prio[shown_next]} == best)
		else $error("shown page not of best priority");
	AST_SINGLE_STAY: assert property (shown_valid_reg && !alarm_shown_reg && cand_cnt == 6'h01
		&& cand[shown_reg] && !head_ok |=> shown_reg == $past(shown_reg))
		else $error("single page rotated");
	AST_BUTTONS: assert property (!ctrl_reg[CTRL_BTN_BIT] |=> button_enable_out == 8'h00)
		else $error("buttons active without global enable");
	AST_LANG_DEF: assert property (!ctrl_reg[CTRL_LANG_BIT] |=> language_out == $past(ldef_reg))
		else $error("language not default");
	AST_ROLL_RANGE: assert property (reg_wr && reg_addr < ADDR_CTRL
		|=> roll[$past(reg_addr[4:0])] >= ROLL_MIN_S && roll[$past(reg_addr[4:0])] <= ROLL_MAX_S)
		else $error("rolling time out of range");

	COV_ALARM_ACK: cover property (ack_hit ##1 ack_pulse_out != 0);
	COV_ROTATE: cover property (expire && tmr_run ##1 shown_reg != $past(shown_reg));
	COV_TWO_ALARMS: cover property (q_cnt_reg == 6'h02 ##[1:50] q_cnt_reg == 6'h01);
endmodule : tpda_arbiter

// *** design/tpda_pkg.sv ***
// package of shared constants for the text page display arbiter
// assumes a single 250 MHz clock and a word-addressed register port
package tpda_pkg;
	// ==================================================================
	// geometry
	localparam int PAGES = 32;
	localparam int PAGE_ROWS = 6;
	localparam int PAGE_COLS = 16;
	localparam int PAGE_CELLS = PAGE_ROWS * PAGE_COLS;
	localparam int LANGS = 8;
	// ==================================================================
	// timing
	localparam int SECOND_NS = 1_000_000_000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam logic [4:0] ROLL_MIN_S = 5'h01;
	localparam logic [4:0] ROLL_MAX_S = 5'h1e;
	// ==================================================================
	// register word addresses
	localparam logic [7:0] ADDR_PAGE_CFG = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h20;
	localparam logic [7:0] ADDR_LANG_DEF = 8'h22;
	localparam logic [7:0] ADDR_LANG_TAB = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h30;
	// ==================================================================
	// page config fields
	localparam int PCFG_PRIO_LSB = 0;
	localparam int PCFG_ROLL_LSB = 8;
	localparam int PCFG_ALARM_BIT = 16;
	localparam int PCFG_LIGHT_LSB = 17;
	localparam int PCFG_BTN_LSB = 24;
	localparam logic [31:0] PCFG_RESET = 32'h0000_0100;
	// ctrl and language table fields
	localparam int CTRL_BTN_BIT = 0;
	localparam int CTRL_LANG_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int LTAB_VALID_BIT = 8;
	// status fields
	localparam int STAT_VALID_BIT = 8;
	localparam int STAT_ALARM_BIT = 9;
	localparam int STAT_LANG_LSB = 16;
	localparam int STAT_QCNT_LSB = 24;
	// ==================================================================
	// backlight colours
	typedef enum logic [1:0] {
		TPDA_WHITE = 2'h0,
		TPDA_GREEN = 2'h1,
		TPDA_RED = 2'h2
	} tpda_colour_type;
endpackage : tpda_pkg

// *** design/tpda_edge_sync.sv ***
// two-stage synchroniser with previous-sample rising edge detect
// assumes inputs are asynchronous levels held for several clocks
`timescale 1ns/1ps
module tpda_edge_sync #(
	parameter int WIDTH = 32
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] lvl,
	output logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] meta_reg, sync_reg, prev_reg;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign lvl = sync_reg;
	// one sample per clock: high now, low the sample before
	assign rise = sync_reg & ~prev_reg;
endmodule : tpda_edge_sync

// *** design/tpda_roll_timer.sv ***
// rolling time counter in whole seconds
// assumes load is a one-cycle request; expire is a one-cycle pulse
`timescale 1ns/1ps
module tpda_roll_timer #(
	parameter int SEC_CYC = 250_000_000
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic load,
	input wire logic [4:0] load_sec,
	input wire logic run,
	output logic expire
);
	logic [27:0] cyc_reg, cyc_next;
	logic [4:0] sec_reg, sec_next;
	logic exp_reg, exp_next;

	always_comb begin
		cyc_next = cyc_reg;
		sec_next = sec_reg;
		exp_next = 1'b0;
		if (load) begin
			cyc_next = 28'(SEC_CYC - 1);
			sec_next = load_sec;
		end else if (run) begin
			if (cyc_reg != 28'h000_0000) begin
				cyc_next = cyc_reg - 28'h000_0001;
			end else if (sec_reg > 5'h01) begin
				cyc_next = 28'(SEC_CYC - 1);
				sec_next = sec_reg - 5'h01;
			end else begin
				exp_next = 1'b1;
				cyc_next = 28'(SEC_CYC - 1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cyc_reg <= 28'h000_0000;
			sec_reg <= 5'h01;
			exp_reg <= 1'b0;
		end else begin
			cyc_reg <= cyc_next;
			sec_reg <= sec_next;
			exp_reg <= exp_next;
		end
	end

	assign expire = exp_reg;
endmodule : tpda_roll_timer

// *** tb/tpda_operator_model.sv ***
// operator and control program model driving page enables and alarm acks
// assumes the bench issues one-cycle ack requests and level enable requests
`timescale 1ns/1ps
module tpda_operator_model (
	input wire logic clk_sys,
	input wire logic [31:0] en_req,
	input wire logic [31:0] ack_req,
	output logic [31:0] page_enable_in,
	output logic [31:0] alarm_ack_in
);
	logic [3:0] hold_cnt;
	initial begin
		page_enable_in = 32'h0000_0000;
		alarm_ack_in = 32'h0000_0000;
		hold_cnt = 4'h0;
	end
	// ==================================================================
	// ack held a few scans, then dropped so the next alarm sees a fresh edge
	always @(posedge clk_sys) begin
		page_enable_in <= en_req;
		if (ack_req != 32'h0000_0000) begin
			alarm_ack_in <= ack_req;
			hold_cnt <= 4'h8;
		end else if (hold_cnt != 4'h0) begin
			hold_cnt <= hold_cnt - 4'h1;
		end else begin
			alarm_ack_in <= 32'h0000_0000;
		end
	end
endmodule : tpda_operator_model

// *** tb/tb.sv ***
// self-checking bench for the text page display arbiter
// assumes the arbiter with a short second (SEC cycles) and the operator model
`timescale 1ns/1ps
module tb;
	import tpda_pkg::*;
	localparam int SEC = 20;
	logic clk_sys, rstn, reg_wr, reg_rd, elem_colour_valid, shown_valid_out, cell_valid_out, seen;
	logic [7:0] reg_addr, language_select_byte, button_enable_out;
	logic [31:0] reg_wdata, reg_rdata, en_req, ack_req, page_enable_in, alarm_ack_in, rd_val;
	logic [31:0] enable_echo_out, ack_pulse_out;
	logic [2:0] elem_row, language_out;
	logic [3:0] elem_col;
	logic [1:0] elem_colour, backlight_output, colour_out;
	logic [4:0] shown_page_out;
	logic [11:0] cell_addr_out;
	int fail_count, checked;
	// ==================================================================
	// instances
	tpda_arbiter #(.SEC_CYC(SEC)) i_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .page_enable_in, .alarm_ack_in, .language_select_byte, .elem_row,
		.elem_col, .elem_colour_valid, .elem_colour, .enable_echo_out, .ack_pulse_out,
		.shown_page_out, .shown_valid_out, .backlight_output, .button_enable_out,
		.language_out, .cell_addr_out, .cell_valid_out, .colour_out);
	tpda_operator_model i_op (.clk_sys, .en_req, .ack_req, .page_enable_in, .alarm_ack_in);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// ==================================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic set_en(input logic [31:0] v);
		@(posedge clk_sys);
		en_req <= v;
	endtask : set_en
	task automatic ack(input int idx);
		@(posedge clk_sys);
		ack_req <= 32'h0000_0001 << idx;
		@(posedge clk_sys);
		ack_req <= 32'h0000_0000;
	endtask : ack
	// bounded wait for a page to become the shown one, then compare
	task automatic wait_shown(input logic [4:0] idx, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			#1;
			if (shown_valid_out === 1'b1 && shown_page_out === idx) break;
		end
		chk(32'({shown_valid_out, shown_page_out}), 32'({1'b1, idx}));
	endtask : wait_shown
	task automatic watch(input logic [31:0] mask);
		seen = 1'b0;
		repeat (20) begin
			@(posedge clk_sys);
			#1;
			if ((ack_pulse_out & mask) != 32'h0000_0000) seen = 1'b1;
		end
	endtask : watch
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : settle
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	// ==================================================================
	// tests
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		en_req = 32'h0000_0000;
		ack_req = 32'h0000_0000;
		language_select_byte = 8'h00;
		elem_row = 3'h0;
		elem_col = 4'h0;
		elem_colour_valid = 1'b0;
		elem_colour = 2'h0;
		fail_count = 0;
		checked = 0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h01, rd_val);
		chk(rd_val, PCFG_RESET);
		rd(ADDR_CTRL, rd_val);
		chk(rd_val, CTRL_RESET);
		rd(8'h3f, rd_val);
		chk(rd_val, 32'h0000_0000);
		wr(8'h04, 32'h0000_1f1f);
		rd(8'h04, rd_val);
		chk(rd_val, 32'h0000_1e1f);
		wr(8'h03, 32'h0000_011f);
		wr(8'h05, 32'h0000_0100);
		wr(8'h0a, 32'ha505_0100);
		wr(8'h0b, 32'h0001_0100);
		$display("test registers done");
		set_en(32'h0000_0008);
		wait_shown(5'd3, 20);
		chk(enable_echo_out, 32'h0000_0008);
		repeat (60) @(posedge clk_sys);
		wait_shown(5'd3, 1);
		set_en(32'h0000_0028);
		wait_shown(5'd5, 20);
		set_en(32'h0000_0008);
		wait_shown(5'd3, 20);
		set_en(32'h0000_0018);
		wait_shown(5'd4, 2 * SEC + 20);
		wait_shown(5'd3, 30 * SEC + 40);
		$display("test priority done");
		set_en(32'h0000_0408);
		wait_shown(5'd10, 10);
		elem_row <= 3'h2;
		elem_col <= 4'h5;
		settle();
		chk(32'(backlight_output), 32'(TPDA_RED));
		chk(32'(colour_out), 32'(TPDA_RED));
		chk(32'({cell_valid_out, cell_addr_out}), 32'h0000_13e5);
		elem_colour_valid <= 1'b1;
		elem_colour <= TPDA_GREEN;
		elem_row <= 3'h6;
		settle();
		chk(32'(colour_out), 32'(TPDA_GREEN));
		chk(32'(cell_valid_out), 32'h0000_0000);
		chk(32'(button_enable_out), 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0003);
		wr(ADDR_LANG_DEF, 32'h0000_0003);
		wr(8'h2a, 32'h0000_0105);
		language_select_byte <= 8'h05;
		settle();
		chk(32'(button_enable_out), 32'h0000_00a5);
		chk(32'(language_out), 32'h0000_0002);
		language_select_byte <= 8'h09;
		settle();
		chk(32'(language_out), 32'h0000_0003);
		rd(ADDR_STATUS, rd_val);
		chk(32'(rd_val[9:0]), 32'h0000_030a);
		ack(3);
		watch(32'hffff_ffff);
		chk(32'(seen), 32'h0000_0000);
		wait_shown(5'd10, 1);
		ack(10);
		watch(32'h0000_0400);
		chk(32'(seen), 32'h0000_0001);
		wait_shown(5'd3, 20);
		$display("test alarm done");
		set_en(32'h0000_0008);
		settle();
		set_en(32'h0000_0808);
		wait_shown(5'd11, 10);
		set_en(32'h0000_0c08);
		repeat (10) @(posedge clk_sys);
		wait_shown(5'd11, 1);
		ack(11);
		wait_shown(5'd10, 20);
		ack(10);
		wait_shown(5'd3, 20);
		$display("test alarm order done");
		report_and_stop();
	end
	// the longest wait is the 30 s rotation; the limit leaves ample margin
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		report_and_stop();
	end
endmodule : tb
